// ### logic/usbp_map.svh
// Register map, field positions and reset values of the shadow data port
// What this block does
// - Sixteen consecutive 32-bit words all alias the same receive/transmit data port.
// - Reading bits 7:0 returns the byte received on the serial input, or on the infrared input in infrared mode.
// - The read byte means something only while the receive data-valid flag is set.
// - With FIFOs off, a new character overwrites an unread byte and flags an overrun.
// - With FIFOs on, a read returns the oldest byte at the head of the receive FIFO.
// - With the receive FIFO full, a new character is dropped, the FIFO kept and an overrun flagged.
// - A written byte is sent on the serial output, or on the active-low infrared output in infrared mode.
// - With FIFOs off and the holding-empty flag set, one write clears that flag.
// - With FIFOs off, another write before the flag sets again replaces the pending byte.
// - With FIFOs on, as many writes as the FIFO depth, 16 by default, are taken before it is full.
// - A write while the transmit FIFO is full is dropped and the FIFO is left as it was.
`ifndef USBP_MAP_SVH
`define USBP_MAP_SVH
`define USBP_WIN_BASE    32'h5000_1130
`define USBP_SLOT2_ADDR  32'h5000_1138
`define USBP_CTRL_ADDR   32'h5000_1170
`define USBP_LSTAT_ADDR  32'h5000_1174
`define USBP_ISTAT_ADDR  32'h5000_1178
`define USBP_IMASK_ADDR  32'h5000_117c
`define USBP_WIN_LSB     6
`define USBP_CTRL_FIFO   0
`define USBP_CTRL_IR     1
`define USBP_LS_DR       0
`define USBP_LS_OVR      1
`define USBP_LS_TX_HOLDING_EMPTY_FLAG     5
`define USBP_LS_TEMT     6
`define USBP_EV_RX       0
`define USBP_EV_OVR      1
`define USBP_EV_TXE      2
`define USBP_EV_W        3
`define USBP_CTRL_RST    2'h0
`define USBP_MASK_RST    3'h0
`define USBP_SUB_LAST    4'hf
`define USBP_SUB_MID     4'h7
`define USBP_IR_PULSE    4'h3
`endif

// ### logic/usbp_pkg.sv
// Types shared by the shadow data port
package usbp_pkg;
  // Serial line states, Gray coded along idle-start-data-stop
  typedef enum logic [1:0] {
    LN_IDLE  = 2'b00,
    LN_START = 2'b01,
    LN_DATA  = 2'b11,
    LN_STOP  = 2'b10
  } usbp_line_t;
endpackage

// ### logic/usbp_uart_shadow_buffer_port.sv
// Shadow receive/transmit data port of the second UART with its FIFOs and line logic
//
// Design decision made here: strobed register access.
`include "usbp_map.svh"

module usbp_uart_shadow_buffer_port
#(
  parameter int FIFO_DEPTH = 16,
  parameter int TICK_DIV   = 8
)
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [31:0] regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  input  wire logic        serialIn,
  input  wire logic        irIn,
  output logic             serialOut,
  output logic             irOutN,
  output logic             irq
);

  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = PW + 1;
  localparam int DW = $clog2(TICK_DIV + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);
  localparam logic [DW-1:0] DIV_LAST = DW'(TICK_DIV - 1);

  // Refuse depths the pointer wrap cannot serve and a zero divider
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 || TICK_DIV < 1)
  begin : g_bad_param
    $error("FIFO_DEPTH must be a power of two of at least 2, TICK_DIV at least 1");
  end

  // Control and status state
  logic [1:0]              ctrl;
  logic                    overrun;
  logic [`USBP_EV_W-1:0]   intStat;
  logic [`USBP_EV_W-1:0]   intMask;
  logic                    threPrev;

  // Receive FIFO
  logic [7:0]    rxMem [FIFO_DEPTH];
  logic [PW-1:0] rxRd;
  logic [PW-1:0] rxWr;
  logic [CW-1:0] rxCount;

  // Transmit FIFO
  logic [7:0]    txMem [FIFO_DEPTH];
  logic [PW-1:0] txRd;
  logic [PW-1:0] txWr;
  logic [CW-1:0] txCount;

  // Line side state
  logic [DW-1:0]         divCnt;
  logic                  irHeld;
  logic [2:0]            syncA [2];
  logic [1:0]            pinStable;
  usbp_pkg::usbp_line_t  txState;
  logic [3:0]            txSub;
  logic [2:0]            txBit;
  logic [7:0]            txShift;
  usbp_pkg::usbp_line_t  rxState;
  logic [3:0]            rxSub;
  logic [2:0]            rxBit;
  logic [7:0]            rxShift;
  logic                  rxDone;

  // Address decode
  wire fifoEn   = ctrl[`USBP_CTRL_FIFO];
  wire irMode   = ctrl[`USBP_CTRL_IR];
  wire [31:0] winOff = regAddr - `USBP_WIN_BASE;                 // Window is not 64-byte aligned
  wire winHit   = winOff[31:`USBP_WIN_LSB] == '0;
  wire ctrlHit  = regAddr == `USBP_CTRL_ADDR;
  wire lstatHit = regAddr == `USBP_LSTAT_ADDR;
  wire istatHit = regAddr == `USBP_ISTAT_ADDR;
  wire imaskHit = regAddr == `USBP_IMASK_ADDR;
  wire dataWr   = regWrite && winHit;
  wire dataRd   = regRead && winHit;
  wire ctrlWr   = regWrite && ctrlHit;
  wire flush    = ctrlWr && regWrData[`USBP_CTRL_FIFO] != fifoEn;

  // Receive FIFO control
  wire rxValid  = rxCount != '0;
  wire rxPop    = dataRd && rxValid;
  wire rxFull   = fifoEn ? rxCount == DEPTH_C : rxValid;
  wire rxBlock  = rxDone && rxFull && !rxPop;
  wire rxOver   = rxBlock && !fifoEn;
  wire rxDrop   = rxBlock && fifoEn;
  wire rxPush   = rxDone && !rxOver && !rxDrop;
  wire overEv   = rxBlock;

  // Transmit FIFO control
  wire txIdle   = txState == usbp_pkg::LN_IDLE;
  wire txEmpty  = txCount == '0;
  wire txPop    = txIdle && !txEmpty;
  wire txFull   = fifoEn ? txCount == DEPTH_C : !txEmpty;
  wire txPush   = dataWr && (!txFull || (!fifoEn && txPop));
  wire txOver   = dataWr && !fifoEn && !txEmpty && !txPop;
  wire tx_holding_empty_flag     = txEmpty;
  wire threEv   = tx_holding_empty_flag && !threPrev;

  // Line status word
  wire [31:0] lstatWord = {25'h0, txEmpty && txIdle, tx_holding_empty_flag, 3'h0, overrun, rxValid};

  // Read selection; data port upper bits read as zero
  wire [31:0] readMux =
    winHit   ? {24'h0, rxMem[rxRd]} :
    ctrlHit  ? {30'h0, ctrl} :
    lstatHit ? lstatWord :
    istatHit ? {29'h0, intStat} :
    imaskHit ? {29'h0, intMask} : 32'h0;

  wire [`USBP_EV_W-1:0] events = {threEv, overEv, rxPush};
  wire [`USBP_EV_W-1:0] clrBits =
    (regWrite && istatHit) ? regWrData[`USBP_EV_W-1:0] : '0;

  // Bus read data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    regRdData <= (regRead && !sys_rst) ? readMux : 32'h0;
  end

  // Control and mask registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl    <= `USBP_CTRL_RST;
      intMask <= `USBP_MASK_RST;
    end
    else
    begin
      if (ctrlWr)
        ctrl <= regWrData[1:0];
      if (regWrite && imaskHit)
        intMask <= regWrData[`USBP_EV_W-1:0];
    end
  end

  // Overrun flag clears on line status read, a new overrun wins
  always_ff @(posedge clk)
  begin
    overrun <= !sys_rst && (overEv || (overrun && !(regRead && lstatHit)));
  end

  // Sticky event bits, write one to clear, set wins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      intStat  <= '0;
      threPrev <= 1'b1;
      irq      <= 1'b0;
    end
    else
    begin
      intStat  <= (intStat & ~clrBits) | events;
      threPrev <= tx_holding_empty_flag;
      irq      <= |(((intStat & ~clrBits) | events) & intMask);
    end
  end

  // Receive FIFO storage
  always_ff @(posedge clk)
  begin
    if (rxPush)
      rxMem[rxWr] <= rxShift;
    else if (rxOver)
      rxMem[rxRd] <= rxShift;
  end

  // Receive FIFO pointers; a full FIFO keeps its contents
  always_ff @(posedge clk)
  begin
    if (sys_rst || flush)
    begin
      rxRd    <= '0;
      rxWr    <= '0;
      rxCount <= '0;
    end
    else
    begin
      if (rxPush)
        rxWr <= rxWr + 1'b1;
      if (rxPop)
        rxRd <= rxRd + 1'b1;
      rxCount <= rxCount + CW'(rxPush) - CW'(rxPop);
    end
  end

  // Transmit FIFO storage; a pending byte is replaced without FIFOs
  always_ff @(posedge clk)
  begin
    if (txPush)
      txMem[txWr] <= regWrData[7:0];
    else if (txOver)
      txMem[txRd] <= regWrData[7:0];
  end

  // Transmit FIFO pointers; writes to a full FIFO are dropped
  always_ff @(posedge clk)
  begin
    if (sys_rst || flush)
    begin
      txRd    <= '0;
      txWr    <= '0;
      txCount <= '0;
    end
    else
    begin
      if (txPush)
        txWr <= txWr + 1'b1;
      if (txPop)
        txRd <= txRd + 1'b1;
      txCount <= txCount + CW'(txPush) - CW'(txPop);
    end
  end

  // Sixteen-times oversampling enable, one cycle in TICK_DIV
  wire tick = divCnt == DIV_LAST;
  always_ff @(posedge clk)
  begin
    divCnt <= (sys_rst || tick) ? '0 : divCnt + 1'b1;
  end

  // Pin synchronisers: a level counts once stages two and three agree
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_sync
    wire pinIn = (gi == 0) ? serialIn : irIn;
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        syncA[gi]     <= {3{gi == 0}};
        pinStable[gi] <= (gi == 0);
      end
      else
      begin
        syncA[gi] <= {syncA[gi][1:0], pinIn};
        if (syncA[gi][1] == syncA[gi][2])
          pinStable[gi] <= syncA[gi][2];
      end
    end
  end

  // Infrared zero pulses are short, so one is held until the cell's sample point
  wire rxMid    = rxState == usbp_pkg::LN_START ? rxSub == `USBP_SUB_MID :
                  rxState != usbp_pkg::LN_IDLE && rxSub == `USBP_SUB_LAST;
  wire rxSample = tick && rxMid;
  wire rxLine   = irMode ? !(irHeld || pinStable[1]) : pinStable[0];

  // Transmit bit value by state
  wire txBitVal = (txState == usbp_pkg::LN_START) ? 1'b0 :
                  (txState == usbp_pkg::LN_DATA) ? txShift[0] : 1'b1;
  wire subEnd   = txSub == `USBP_SUB_LAST;

  // Transmit shifter
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      txState <= usbp_pkg::LN_IDLE;
      txSub   <= '0;
      txBit   <= '0;
      txShift <= '0;
    end
    else if (txPop)
    begin
      txShift <= txMem[txRd];
      txState <= usbp_pkg::LN_START;
      txSub   <= '0;
      txBit   <= '0;
    end
    else if (tick && !txIdle)
    begin
      txSub <= txSub + 1'b1;
      if (subEnd)
      begin
        unique case (txState)
          usbp_pkg::LN_START: txState <= usbp_pkg::LN_DATA;
          usbp_pkg::LN_DATA:
          begin
            txShift <= {1'b1, txShift[7:1]};
            txBit   <= txBit + 1'b1;
            if (txBit == 3'h7)
              txState <= usbp_pkg::LN_STOP;
          end
          usbp_pkg::LN_STOP: txState <= usbp_pkg::LN_IDLE;
          usbp_pkg::LN_IDLE: txState <= usbp_pkg::LN_IDLE;
        endcase
      end
    end
  end

  // Line outputs: serial level, or short low pulses for infrared zeros
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      serialOut <= 1'b1;
      irOutN    <= 1'b1;
    end
    else
    begin
      serialOut <= irMode | txBitVal;
      irOutN    <= !(irMode && !txBitVal && txSub < `USBP_IR_PULSE);
    end
  end

  // Receive shifter, samples each bit mid-cell
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rxState <= usbp_pkg::LN_IDLE;
      rxSub   <= '0;
      rxBit   <= '0;
      rxShift <= '0;
      rxDone  <= 1'b0;
      irHeld  <= 1'b0;
    end
    else
    begin
      rxDone <= 1'b0;
      irHeld <= rxSample ? 1'b0 : irHeld || pinStable[1];
      if (tick)
      begin
        rxSub <= rxSub + 1'b1;
        unique case (rxState)
          usbp_pkg::LN_IDLE:
          begin
            rxSub <= '0;
            if (!rxLine)
              rxState <= usbp_pkg::LN_START;
          end
          usbp_pkg::LN_START:
            if (rxSub == `USBP_SUB_MID)
            begin
              rxSub   <= '0;
              rxBit   <= '0;
              rxState <= rxLine ? usbp_pkg::LN_IDLE : usbp_pkg::LN_DATA;
            end
          usbp_pkg::LN_DATA:
            if (rxSub == `USBP_SUB_LAST)
            begin
              rxShift <= {rxLine, rxShift[7:1]};
              rxBit   <= rxBit + 1'b1;
              if (rxBit == 3'h7)
                rxState <= usbp_pkg::LN_STOP;
            end
          usbp_pkg::LN_STOP:
            if (rxSub == `USBP_SUB_LAST)
            begin
              rxDone  <= rxLine;
              rxState <= usbp_pkg::LN_IDLE;
            end
        endcase
      end
    end
  end

endmodule

// ### test/usbp_peer.sv
// Remote serial and infrared peer on the line side of the data port
module usbp_peer
#(
  parameter int TICK_DIV = 1
)
(
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic irTxN,
  output logic      rxd,
  output logic      irRx
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BT = 16 * TICK_DIV;
  logic [7:0] got[$];
  int         irPulses = 0;
  logic [7:0] sh;

  // Wire idles high, infrared receiver idles dark
  initial
  begin
    rxd = 1'b1;
    irRx = 1'b0;
  end

  // Sends one 8N1 frame LSB first, as levels or as short infrared pulses
  task automatic send(input logic [7:0] b, input logic ir);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      rxd <= ir | f[i];
      irRx <= ir & !f[i];
      repeat (3 * TICK_DIV) @(posedge clk);
      irRx <= 1'b0;
      repeat (BT - 3 * TICK_DIV - 1) @(posedge clk);
    end
  endtask

  // Samples every frame from the device at mid-bit
  always
  begin
    @(negedge txd);
    repeat (BT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BT) @(posedge clk);
      sh[i] = txd;
    end
    repeat (BT) @(posedge clk);
    got.push_back(sh);
  end

  // Counts infrared zero-bit pulses from the device
  always @(negedge irTxN) irPulses++;
endmodule

// ### test/usbp_props.sv
// Port-level checks of the shadow data port
module usbp_props
#(
  parameter int TICK_DIV = 8
)
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [31:0] regAddr,
  input wire logic        regRead,
  input wire logic [31:0] regRdData,
  input wire logic        serialOut,
  input wire logic        irOutN,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MAX_LOW = 145 * TICK_DIV;
  int   lowRun;
  int   irLow;
  logic inWin;
  logic mapped;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Data window and register block decode
  assign inWin  = regAddr >= 32'h5000_1130 && regAddr <= 32'h5000_116f;
  assign mapped = inWin || (regAddr >= 32'h5000_1170 && regAddr <= 32'h5000_117f);

  // Length of the current low run on each transmit pin
  always_ff @(posedge clk)
  begin
    lowRun <= (sys_rst || serialOut) ? 0 : lowRun + 1;
    irLow  <= (sys_rst || irOutN) ? 0 : irLow + 1;
  end

  property p_rd_hi_zero;
    $past(regRead) && $past(inWin) |-> regRdData[31:8] == 24'h0;
  endproperty
  a_rd_hi_zero: assert property (p_rd_hi_zero) else $error("upper data bits set");
  property p_rd_idle;
    !$past(regRead) |-> regRdData == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
  property p_unmapped;
    $past(regRead) && !$past(mapped) |-> regRdData == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rst_lines;
    $past(sys_rst) |-> serialOut && irOutN && !irq && regRdData == 32'h0;
  endproperty
  a_rst_lines: assert property (p_rst_lines) else $error("outputs not idle after reset");
  property p_start_hold;
    $fell(serialOut) |-> !serialOut [*8];
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start bit too short");
  property p_low_run;
    lowRun <= MAX_LOW;
  endproperty
  a_low_run: assert property (p_low_run) else $error("serial line low too long");
  property p_ir_pulse;
    $rose(irOutN) |-> irLow == 3 * TICK_DIV;
  endproperty
  a_ir_pulse: assert property (p_ir_pulse) else $error("infrared pulse width");
  property p_ir_quiet;
    !irOutN |-> serialOut;
  endproperty
  a_ir_quiet: assert property (p_ir_quiet) else $error("serial active in infrared");
endmodule

// ### test/testbench.sv
// Self-checking bench of the shadow data port with its line peer
`include "usbp_map.svh"
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin nFail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TD    = 1;
  localparam int DEPTH = 16;
  logic        clk;
  logic        sys_rst;
  logic [31:0] regAddr;
  logic [31:0] regWrData;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdData;
  logic        serialIn;
  logic        irIn;
  logic        serialOut;
  logic        irOutN;
  logic        irq;
  int          nFail = 0;
  int          checksDone = 0;

  usbp_uart_shadow_buffer_port #(.FIFO_DEPTH(DEPTH), .TICK_DIV(TD)) dut_u
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .regWrite  (regWrite),
    .regRead   (regRead),
    .regRdData (regRdData),
    .serialIn  (serialIn),
    .irIn      (irIn),
    .serialOut (serialOut),
    .irOutN    (irOutN),
    .irq       (irq)
  );

  usbp_peer #(.TICK_DIV(TD)) peer_u
  (
    .clk   (clk),
    .txd   (serialOut),
    .irTxN (irOutN),
    .rxd   (serialIn),
    .irRx  (irIn)
  );

  // Bus write and checked bus read
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdChk(input logic [31:0] a, e, m = 32'hffff_ffff);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    `CHK(regRdData & m, e)
  endtask
  task automatic waitTx(input int n);
    for (int i = 0; i < 4000 && peer_u.got.size() < n; i++) @(posedge clk);
  endtask

  task automatic s_idle();
    rdChk(`USBP_SLOT2_ADDR, 32'h0, 32'hffff_ff00);
    rdChk(`USBP_LSTAT_ADDR, 32'h60);
    rdChk(32'h5000_1180, 32'h0);
  endtask
  task automatic s_rx_plain();
    wr(`USBP_IMASK_ADDR, 32'h3);
    peer_u.send(8'h3c, 1'b0);
    repeat (8) @(posedge clk);
    rdChk(`USBP_LSTAT_ADDR, 32'h61);
    `CHK(irq, 1'b1)
    peer_u.send(8'hc3, 1'b0);
    repeat (8) @(posedge clk);
    rdChk(`USBP_ISTAT_ADDR, 32'h3, 32'h3);
    rdChk(`USBP_LSTAT_ADDR, 32'h63);
    rdChk(`USBP_WIN_BASE + 32'h3c, 32'hc3);
    rdChk(`USBP_LSTAT_ADDR, 32'h60);
    wr(`USBP_ISTAT_ADDR, 32'h7);
    @(posedge clk);
    @(negedge clk);
    `CHK(irq, 1'b0)
  endtask
  task automatic s_rx_fifo();
    wr(`USBP_CTRL_ADDR, 32'h1);
    for (int i = 1; i <= DEPTH + 1; i++) peer_u.send(8'(i), 1'b0);
    repeat (8) @(posedge clk);
    rdChk(`USBP_LSTAT_ADDR, 32'h63);
    for (int i = 1; i <= DEPTH; i++) rdChk(`USBP_WIN_BASE + 32'(4 * i - 4), 32'(i));
    rdChk(`USBP_LSTAT_ADDR, 32'h60);
  endtask
  task automatic s_tx_plain();
    wr(`USBP_CTRL_ADDR, 32'h0);
    peer_u.got.delete();
    rdChk(`USBP_LSTAT_ADDR, 32'h60);
    wr(`USBP_SLOT2_ADDR, 32'h11);
    wr(`USBP_SLOT2_ADDR, 32'h22);
    rdChk(`USBP_LSTAT_ADDR, 32'h0);
    wr(`USBP_SLOT2_ADDR, 32'hffff_ff33);
    waitTx(2);
    `CHK(peer_u.got[0], 8'h11)
    `CHK(peer_u.got[1], 8'h33)
  endtask
  task automatic s_tx_fifo();
    wr(`USBP_CTRL_ADDR, 32'h1);
    peer_u.got.delete();
    for (int i = 0; i < DEPTH + 2; i++) wr(`USBP_SLOT2_ADDR, 32'h40 + 32'(i));
    waitTx(DEPTH + 1);
    repeat (200) @(posedge clk);
    `CHK(peer_u.got.size(), DEPTH + 1)
    for (int i = 0; i <= DEPTH; i++) `CHK(peer_u.got[i], 8'h40 + 8'(i))
  endtask
  task automatic s_ir();
    wr(`USBP_CTRL_ADDR, 32'h3);
    peer_u.send(8'h5a, 1'b1);
    repeat (8) @(posedge clk);
    rdChk(`USBP_SLOT2_ADDR, 32'h5a);
    peer_u.irPulses = 0;
    wr(`USBP_SLOT2_ADDR, 32'ha5);
    repeat (12 * 16 * TD) @(posedge clk);
    `CHK(peer_u.irPulses, 5)
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    nFail++;
    end_of_test();
  end

  // Reset, then the scenarios in turn
  initial
  begin
    sys_rst = 1'b1;
    regAddr = 32'h0;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    s_idle();
    s_rx_plain();
    s_rx_fifo();
    s_tx_plain();
    s_tx_fifo();
    s_ir();
    end_of_test();
  end
endmodule

bind usbp_uart_shadow_buffer_port usbp_props #(.TICK_DIV(TICK_DIV)) props_u
(
  .clk       (clk),
  .sys_rst   (sys_rst),
  .regAddr   (regAddr),
  .regRead   (regRead),
  .regRdData (regRdData),
  .serialOut (serialOut),
  .irOutN    (irOutN),
  .irq       (irq)
);
